//--- pkg/cmd_decode_map.svh
`ifndef CMD_DECODE_MAP_SVH
`define CMD_DECODE_MAP_SVH

// Address and bank widths of the command bus.
`define ADDR_W 16
`define BANK_W 3
// Position of the auto precharge / all banks bit.
`define AP_BIT 10
// Width of the decoded column address.
`define COL_W 15

`endif

//--- pkg/cmd_decode_pkg.sv
`include "cmd_decode_map.svh"

package cmd_decode_pkg;

  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_MODE_LOAD = 4'h2,
    CMD_REFRESH = 4'h3,
    CMD_SELF_REFRESH_ENTRY = 4'h4,
    CMD_POWER_DOWN_ENTRY = 4'h5,
    CMD_CKE_EXIT = 4'h6,
    CMD_PRECHARGE_ONE = 4'h7,
    CMD_PRECHARGE_ALL = 4'h8,
    CMD_ACTIVATE = 4'h9,
    CMD_WRITE = 4'ha,
    CMD_WRITE_AP = 4'hb,
    CMD_READ = 4'hc,
    CMD_READ_AP = 4'hd,
    CMD_ILLEGAL = 4'he
  } cmd_type;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SELF_REFRESH = 2'b10
  } pwr_type;

endpackage : cmd_decode_pkg

//--- pkg/pin_sample_if.sv
`timescale 1ns/10ps
`include "cmd_decode_map.svh"

interface pin_sample_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic cke_prev;
  logic [`BANK_W-1:0] ba;
  logic [`ADDR_W-1:0] addr;
  modport sampler (output cs_n, ras_n, cas_n, we_n, cke, cke_prev, ba,
    addr);
  modport decoder (input cs_n, ras_n, cas_n, we_n, cke, cke_prev, ba, addr);
endinterface : pin_sample_if

//--- hw/pin_sampler.sv
`timescale 1ns/10ps
`include "cmd_decode_map.svh"

module pin_sampler (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Command pins.
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic cke_pin,
  input wire logic [`BANK_W-1:0] ba_pin,
  input wire logic [`ADDR_W-1:0] addr_pin,
  // Synchronised levels.
  pin_sample_if.sampler smp
);

  localparam int W = 5 + `BANK_W + `ADDR_W;

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic cke_prev_r;

  // Two flops on every pin before any decode logic sees it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, cke_pin, ba_pin,
        addr_pin};
      sync_r <= meta_r;
    end
  end

  // Clock enable as seen on the previous edge.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= sync_r[W-5];
    end
  end

  assign smp.cs_n = sync_r[W-1];
  assign smp.ras_n = sync_r[W-2];
  assign smp.cas_n = sync_r[W-3];
  assign smp.we_n = sync_r[W-4];
  assign smp.cke = sync_r[W-5];
  assign smp.cke_prev = cke_prev_r;
  assign smp.ba = sync_r[`BANK_W+`ADDR_W-1:`ADDR_W];
  assign smp.addr = sync_r[`ADDR_W-1:0];

endmodule : pin_sampler

//--- hw/ddr2_command_decoder.sv
`timescale 1ns/10ps
`include "cmd_decode_map.svh"

// What this block does
// - Decode only from levels sampled at rising edge.
// - Truth table encodings with clock enable high.
// - Write carries bank, column; A10 selects auto precharge.
// - Read carries bank, column; A10 selects auto precharge.
// - Clock enable edges enter and leave low power.
// - Precharge A10 picks one or all; activate row.
// - Termination input never affects command decoding.
// - No termination while in self refresh.
// - Top bank bit used only at 1Gb or more.
// - Upper column bits may be ignored by configuration.
// - Mode load bank bits select mode register.
// - Self refresh exit as soon as enable rises.
// - Length four bursts are never interrupted.
module ddr2_command_decoder (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration straps.
  input wire logic density_1g,
  input wire logic [`COL_W-1:0] col_mask,
  input wire logic burst_len4,
  // Command and address pins.
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic cke_pin,
  input wire logic [`BANK_W-1:0] ba_pin,
  input wire logic [`ADDR_W-1:0] addr_pin,
  input wire logic odt_pin,
  // Decoded command.
  output logic cmd_valid,
  output cmd_decode_pkg::cmd_type cmd,
  output logic [`BANK_W-1:0] bank,
  output logic [`ADDR_W-1:0] row,
  output logic [`COL_W-1:0] col,
  output logic [`BANK_W-1:0] mode_reg_sel,
  output logic [`ADDR_W-1:0] mode_opcode,
  // Device state.
  output cmd_decode_pkg::pwr_type pwr_state,
  output logic burst_busy,
  output logic odt_enable
);

  pin_sample_if smp ();

  pin_sampler u_sampler (
    .sys_clk(sys_clk),
    .rst(rst),
    .cs_n_pin(cs_n_pin),
    .ras_n_pin(ras_n_pin),
    .cas_n_pin(cas_n_pin),
    .we_n_pin(we_n_pin),
    .cke_pin(cke_pin),
    .ba_pin(ba_pin),
    .addr_pin(addr_pin),
    .smp(smp)
  );

  cmd_decode_pkg::cmd_type cls;
  cmd_decode_pkg::pwr_type pwr_r;
  cmd_decode_pkg::pwr_type pwr_nxt;
  logic [`BANK_W-1:0] ba_eff;
  logic [`COL_W-1:0] col_raw;
  logic odt_meta_r;
  logic odt_sync_r;
  logic [1:0] burst_cnt_r;
  logic is_col_cmd;

  // The top bank bit only counts in the larger densities.
  assign ba_eff = {smp.ba[`BANK_W-1] & density_1g,
    smp.ba[`BANK_W-2:0]};

  // Column address skips the auto precharge bit.
  assign col_raw = {smp.addr[`ADDR_W-1:`AP_BIT+1],
    smp.addr[`AP_BIT-1:0]};

  // Classification from the registered pin levels only.
  always_comb begin
    cls = cmd_decode_pkg::CMD_ILLEGAL;
    if (!smp.cke_prev) begin
      // Strobes are don't care while clock enable was low.
      if (smp.cke) begin
        cls = cmd_decode_pkg::CMD_CKE_EXIT;
      end else begin
        cls = cmd_decode_pkg::CMD_DESELECT;
      end
    end else if (smp.cs_n) begin
      cls = smp.cke ? cmd_decode_pkg::CMD_DESELECT
        : cmd_decode_pkg::CMD_POWER_DOWN_ENTRY;
    end else if (!smp.cke) begin
      if (!smp.ras_n && !smp.cas_n && smp.we_n) begin
        cls = cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY;
      end else if (smp.ras_n && smp.cas_n && smp.we_n) begin
        cls = cmd_decode_pkg::CMD_POWER_DOWN_ENTRY;
      end
    end else begin
      unique case ({smp.ras_n, smp.cas_n, smp.we_n})
        3'b000: cls = cmd_decode_pkg::CMD_MODE_LOAD;
        3'b001: cls = cmd_decode_pkg::CMD_REFRESH;
        3'b010: cls = smp.addr[`AP_BIT] ? cmd_decode_pkg::CMD_PRECHARGE_ALL
          : cmd_decode_pkg::CMD_PRECHARGE_ONE;
        3'b011: cls = cmd_decode_pkg::CMD_ACTIVATE;
        3'b100: cls = smp.addr[`AP_BIT] ? cmd_decode_pkg::CMD_WRITE_AP
          : cmd_decode_pkg::CMD_WRITE;
        3'b101: cls = smp.addr[`AP_BIT] ? cmd_decode_pkg::CMD_READ_AP
          : cmd_decode_pkg::CMD_READ;
        3'b110: cls = cmd_decode_pkg::CMD_NOP;
        3'b111: cls = cmd_decode_pkg::CMD_NOP;
      endcase
    end
    if (burst_busy && burst_len4 && smp.cke_prev) begin
      if (cls inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_WRITE_AP,
        cmd_decode_pkg::CMD_READ, cmd_decode_pkg::CMD_READ_AP,
        cmd_decode_pkg::CMD_PRECHARGE_ONE,
        cmd_decode_pkg::CMD_PRECHARGE_ALL}) begin
        cls = cmd_decode_pkg::CMD_ILLEGAL;
      end
    end
  end

  assign is_col_cmd = cls inside {cmd_decode_pkg::CMD_WRITE,
    cmd_decode_pkg::CMD_WRITE_AP, cmd_decode_pkg::CMD_READ,
    cmd_decode_pkg::CMD_READ_AP};

  // Power state follows clock enable edges.
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (cls)
      cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY:
        pwr_nxt = cmd_decode_pkg::PWR_SELF_REFRESH;
      cmd_decode_pkg::CMD_POWER_DOWN_ENTRY:
        pwr_nxt = cmd_decode_pkg::PWR_DOWN;
      cmd_decode_pkg::CMD_CKE_EXIT:
        pwr_nxt = cmd_decode_pkg::PWR_ACTIVE;
      default: pwr_nxt = pwr_r;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_r <= cmd_decode_pkg::PWR_ACTIVE;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Self refresh is left the moment clock enable is seen high.
  assign pwr_state = (pwr_r == cmd_decode_pkg::PWR_SELF_REFRESH && smp.cke)
    ? cmd_decode_pkg::PWR_ACTIVE : pwr_r;

  // Length four burst tracker, one more cycle after the column command.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      burst_cnt_r <= 2'h0;
    end else if (is_col_cmd && burst_len4) begin
      burst_cnt_r <= 2'h1;
    end else if (burst_cnt_r != 2'h0) begin
      burst_cnt_r <= burst_cnt_r - 2'h1;
    end
  end

  assign burst_busy = (burst_cnt_r != 2'h0);

  // Decoded outputs, held in flops.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd <= cmd_decode_pkg::CMD_DESELECT;
      bank <= '0;
      row <= '0;
      col <= '0;
      mode_reg_sel <= '0;
      mode_opcode <= '0;
    end else begin
      cmd_valid <= !(cls inside {cmd_decode_pkg::CMD_DESELECT,
        cmd_decode_pkg::CMD_NOP});
      cmd <= cls;
      bank <= ba_eff;
      if (cls == cmd_decode_pkg::CMD_ACTIVATE) begin
        row <= smp.addr;
      end
      if (is_col_cmd) begin
        col <= col_raw & col_mask;
      end
      if (cls == cmd_decode_pkg::CMD_MODE_LOAD) begin
        mode_reg_sel <= ba_eff;
        mode_opcode <= smp.addr;
      end
    end
  end

  // Termination pin only gates the termination output.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      odt_meta_r <= 1'b0;
      odt_sync_r <= 1'b0;
    end else begin
      odt_meta_r <= odt_pin;
      odt_sync_r <= odt_meta_r;
    end
  end

  assign odt_enable = odt_sync_r
    && (pwr_r != cmd_decode_pkg::PWR_SELF_REFRESH);

endmodule : ddr2_command_decoder

//--- bench/ctrl_model.sv
`timescale 1ns/10ps
`include "cmd_decode_map.svh"

module ctrl_model (
  // Clock.
  input wire logic sys_clk,
  // Command and address pins.
  output logic cs_n_pin,
  output logic ras_n_pin,
  output logic cas_n_pin,
  output logic we_n_pin,
  output logic cke_pin,
  output logic [`BANK_W-1:0] ba_pin,
  output logic [`ADDR_W-1:0] addr_pin,
  output logic odt_pin
);
  initial begin
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hf;
    cke_pin = 1'b1;
    ba_pin = 3'h0;
    addr_pin = 16'h0;
    odt_pin = 1'b0;
  end

  // Every pin gets a defined level, even where the command ignores it.
  task automatic issue(input logic k, input logic [3:0] p,
    input logic [`BANK_W-1:0] b, input logic [`ADDR_W-1:0] a);
    @(posedge sys_clk);
    #1;
    cke_pin = k;
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = p;
    ba_pin = b;
    addr_pin = a;
    odt_pin = k ? 1'($urandom) : 1'b1;
  endtask : issue
endmodule : ctrl_model

//--- bench/ddr2_command_decoder_assertions.sv
`timescale 1ns/10ps
`include "cmd_decode_map.svh"

module ddr2_cmd_checker (
  // Clock, reset and strap.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic density_1g,
  // Pins.
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic cke_pin,
  input wire logic [`BANK_W-1:0] ba_pin,
  input wire logic [`ADDR_W-1:0] addr_pin,
  // Decoded outputs.
  input wire cmd_decode_pkg::cmd_type cmd,
  input wire logic [`BANK_W-1:0] bank,
  input wire logic [`ADDR_W-1:0] row,
  input wire logic [`BANK_W-1:0] mode_reg_sel,
  input wire cmd_decode_pkg::pwr_type pwr_state,
  input wire logic odt_enable
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] pins;
  logic ap;
  assign pins = {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
  assign ap = addr_pin[`AP_BIT];

  act_decode_a: assert property (
    cmd == cmd_decode_pkg::CMD_ACTIVATE |-> $past(pins, 3) == 4'h3 &&
    $past(cke_pin, 4) && row == $past(addr_pin, 3))
    else $error("activate decode wrong");
  write_ap_a: assert property (
    cmd inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_WRITE_AP}
    |-> $past(pins, 3) == 4'h4 && $past(ap, 3) == cmd[0])
    else $error("write decode wrong");
  read_ap_a: assert property (
    cmd inside {cmd_decode_pkg::CMD_READ, cmd_decode_pkg::CMD_READ_AP}
    |-> $past(pins, 3) == 4'h5 && $past(ap, 3) == cmd[0])
    else $error("read decode wrong");
  pre_kind_a: assert property (
    cmd inside {[cmd_decode_pkg::CMD_PRECHARGE_ONE:8]}
    |-> $past(pins, 3) == 4'h2 && $past(ap, 3) == !cmd[0])
    else $error("precharge decode wrong");
  self_ref_a: assert property (
    cmd == cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY |-> $past(pins, 3) == 4'h1
    && $past(cke_pin, 4) && !$past(cke_pin, 3))
    else $error("self refresh entry wrong");
  odt_off_a: assert property (
    pwr_state == cmd_decode_pkg::PWR_SELF_REFRESH |-> !odt_enable)
    else $error("termination on in self refresh");
  bank_top_a: assert property (
    !density_1g [*4] |-> bank[`BANK_W-1] == 1'b0)
    else $error("top bank bit not masked");
  mode_sel_a: assert property (
    cmd == cmd_decode_pkg::CMD_MODE_LOAD |-> $past(pins, 3) == 4'h0 &&
    mode_reg_sel[1:0] == $past(ba_pin[1:0], 3))
    else $error("mode register select wrong");
endmodule : ddr2_cmd_checker

bind ddr2_command_decoder ddr2_cmd_checker u_ddr2_cmd_checker (.sys_clk,
  .rst, .density_1g, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
  .cke_pin, .ba_pin, .addr_pin, .cmd, .bank, .row, .mode_reg_sel,
  .pwr_state, .odt_enable);

//--- bench/ddr2_command_decoder_tb.sv
`timescale 1ns/10ps
`include "cmd_decode_map.svh"

module ddr2_command_decoder_tb;
  typedef struct packed {
    cmd_decode_pkg::cmd_type c;
    logic [`BANK_W-1:0] b;
    logic [`ADDR_W-1:0] a;
  } note_type;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic density_1g = 1'b1;
  logic burst_len4 = 1'b1;
  logic [`COL_W-1:0] col_mask = 15'h7fff;
  logic cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, cke_pin, odt_pin;
  logic [`BANK_W-1:0] ba_pin, bank, mode_reg_sel;
  logic [`ADDR_W-1:0] addr_pin, row, mode_opcode;
  logic [`COL_W-1:0] col;
  logic cmd_valid, burst_busy, odt_enable;
  cmd_decode_pkg::cmd_type cmd;
  cmd_decode_pkg::pwr_type pwr_state;
  note_type exp_q[$];
  note_type e;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #2 sys_clk = ~sys_clk;

  ctrl_model u_ctrl_model (.sys_clk, .cs_n_pin, .ras_n_pin, .cas_n_pin,
    .we_n_pin, .cke_pin, .ba_pin, .addr_pin, .odt_pin);
  ddr2_command_decoder u_ddr2_command_decoder (.sys_clk, .rst, .density_1g,
    .col_mask, .burst_len4, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
    .cke_pin, .ba_pin, .addr_pin, .odt_pin, .cmd_valid, .cmd, .bank, .row,
    .col, .mode_reg_sel, .mode_opcode, .pwr_state, .burst_busy, .odt_enable);

  task automatic check(input string n, input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  // Sends one command and notes the decode that it must produce.
  task automatic send(input logic k, input logic [3:0] p,
    input cmd_decode_pkg::cmd_type c);
    logic [`ADDR_W-1:0] a;
    logic [`BANK_W-1:0] b;
    a = `ADDR_W'($urandom);
    b = `BANK_W'($urandom);
    if (a[`AP_BIT] && c inside {cmd_decode_pkg::CMD_WRITE,
      cmd_decode_pkg::CMD_READ, cmd_decode_pkg::CMD_PRECHARGE_ONE})
      c = cmd_decode_pkg::cmd_type'(c + 4'h1);
    u_ctrl_model.issue(k, p, b, a);
    if (c != cmd_decode_pkg::CMD_NOP)
      exp_q.push_back('{c, b & {density_1g, 2'b11}, a});
  endtask : send

  always @(negedge sys_clk) begin
    if (!rst && cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("spare", 16'(cmd), 16'hffff);
      else begin
        e = exp_q.pop_front();
        check("cmd", 16'(cmd), 16'(e.c));
        if (e.c inside {[cmd_decode_pkg::CMD_PRECHARGE_ONE:4'hd]})
          check("bank", 16'(bank), 16'(e.b));
        if (e.c == cmd_decode_pkg::CMD_ACTIVATE)
          check("row", row, e.a);
        if (e.c inside {[cmd_decode_pkg::CMD_WRITE:4'hd]}) begin
          check("col", 16'(col),
            16'({e.a[15:11], e.a[9:0]} & col_mask));
          check("busy", 16'(burst_busy), 16'(burst_len4));
        end
        if (e.c == cmd_decode_pkg::CMD_MODE_LOAD)
          check("opcode", mode_opcode, e.a);
      end
    end
  end

  initial begin
    void'($urandom(17));
    col_mask = `COL_W'($urandom);
    exp_q.push_back('{cmd_decode_pkg::CMD_CKE_EXIT, 3'h0, 16'h0});
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int n = 0; n < 36; n++) begin
      if (n == 18) repeat (4) send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
      density_1g = (n < 18);
      send(1'b1, 4'(n % 6), cmd_decode_pkg::cmd_type'(4'(24'hca9732 >>
        4 * (n % 6))));
      send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
    end
    $display("decode test done");
    send(1'b1, 4'h4, cmd_decode_pkg::CMD_WRITE);
    send(1'b1, 4'h5, cmd_decode_pkg::CMD_ILLEGAL);
    repeat (3) send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
    burst_len4 = 1'b0;
    send(1'b1, 4'h4, cmd_decode_pkg::CMD_WRITE);
    send(1'b1, 4'h5, cmd_decode_pkg::CMD_READ);
    repeat (4) send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
    burst_len4 = 1'b1;
    $display("burst test done");
    send(1'b0, 4'hf, cmd_decode_pkg::CMD_POWER_DOWN_ENTRY);
    repeat (6)
      send(1'b0, 4'($urandom), cmd_decode_pkg::CMD_NOP);
    check("pwr", 16'(pwr_state), 16'(cmd_decode_pkg::PWR_DOWN));
    check("odt on", 16'(odt_enable), 16'h1);
    send(1'b1, 4'hf, cmd_decode_pkg::CMD_CKE_EXIT);
    send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
    send(1'b0, 4'h1, cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY);
    repeat (5) send(1'b0, 4'($urandom), cmd_decode_pkg::CMD_NOP);
    check("odt", 16'(odt_enable), 16'h0);
    check("pwr sr", 16'(pwr_state),
      16'(cmd_decode_pkg::PWR_SELF_REFRESH));
    send(1'b1, 4'hf, cmd_decode_pkg::CMD_CKE_EXIT);
    repeat (2) send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
    check("exit", 16'(pwr_state), 16'(cmd_decode_pkg::PWR_ACTIVE));
    repeat (4) send(1'b1, 4'hf, cmd_decode_pkg::CMD_NOP);
    check("left", 16'(exp_q.size()), 16'h0);
    $display("power test done");
    complete_run();
  end
endmodule : ddr2_command_decoder_tb
